// [hw/idp_core.sv]
// Interrupt decode words, rate pacing and AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite slave port.
`default_nettype none
module idp_core
  import idp_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire idp_src_t          src_i,
  input  wire idp_route_t        route_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [NDST-1:0]        intr_pulse_o
);
  // ------------------------------------------------------------------
  // Status decode
  // ------------------------------------------------------------------
  logic [NDST-1:0][31:0] dec, next_dec;
  logic [NDST-1:0]       pend;

  // Sources are only observed, never cleared here
  always_comb begin : decode_next
    next_dec = '0;
    for (int d = 0; d < NDST; d++) begin
      for (int x = 0; x < 16; x++) begin
        for (int g = 0; g < NDBG; g++) begin
          if (src_i.db[g][x] && idp_hit(route_i.db[g][x], route_i.db_ded, 5'(d))) begin
            next_dec[d][x] = 1'b1;
          end
        end
        if (src_i.sid[x] && idp_hit(route_i.sid[x], 1'b0, 5'(d))) begin
          next_dec[d][BIT_SID_GOOD] = 1'b1;
        end
        if (src_i.sid[x+16] && idp_hit(route_i.sid[x+16], 1'b0, 5'(d))) begin
          next_dec[d][BIT_SID_ERR] = 1'b1;
        end
      end
      for (int u = 0; u < 8; u++) begin
        if (src_i.unit[u] && idp_hit(route_i.unit[u], 1'b0, 5'(d))) begin
          next_dec[d][BIT_UNIT] = 1'b1;
        end
      end
      for (int e = 0; e < 17; e++) begin
        if (src_i.err[e] && idp_hit(route_i.err[e], 1'b0, 5'(d))) begin
          next_dec[d][BIT_ERR] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin : decode_reg
    if (!nrst_i) begin
      dec <= '0;
    end else if (ce_i) begin
      dec <= next_dec;
    end
  end

  always_comb begin : pend_calc
    for (int d = 0; d < NDST; d++) begin
      pend[d] = |dec[d];
    end
  end

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  logic              awready, next_awready, wready, next_wready;
  logic              bvalid, next_bvalid, arready, next_arready;
  logic              rvalid, next_rvalid;
  logic [1:0]        bresp, next_bresp, rresp, next_rresp;
  logic [31:0]       rdata, next_rdata, wdata_q, next_wdata_q;
  logic [3:0]        wstrb_q, next_wstrb_q;
  logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic              wr_go, wa_rate, wa_dis, wa_dec;
  logic [31:0]       rd_val;
  logic              rd_ok;
  logic [NPACE-1:0][31:0] cnt;
  logic [NPACE-1:0]  dis;

  // Address and data may arrive in either order; commit once both held
  assign wr_go   = !awready && !wready && !bvalid;
  assign wa_rate = awaddr_q[11:6] == ADDR_RATE[11:6];
  assign wa_dis  = awaddr_q[11:2] == ADDR_DIS[11:2];
  assign wa_dec  = awaddr_q[11:7] == ADDR_DEC[11:7] && awaddr_q[6:2] < 5'(NDST);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin : read_mux
    rd_val = '0;
    rd_ok  = 1'b1;
    if (s_axi_araddr_i[11:7] == ADDR_DEC[11:7] && s_axi_araddr_i[6:2] < 5'(NDST)) begin
      rd_val = dec[s_axi_araddr_i[6:2]];
    end else if (s_axi_araddr_i[11:6] == ADDR_RATE[11:6]) begin
      rd_val = cnt[s_axi_araddr_i[5:2]];
    end else if (s_axi_araddr_i[11:2] == ADDR_DIS[11:2]) begin
      rd_val = {16'h0000, dis};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin : bus_next
    next_awready  = awready;
    next_wready   = wready;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_awaddr_q = awaddr_q;
    next_wdata_q  = wdata_q;
    next_wstrb_q  = wstrb_q;
    next_arready  = arready;
    next_rvalid   = rvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    if (s_axi_awvalid_i && awready) begin
      next_awready  = 1'b0;
      next_awaddr_q = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready) begin
      next_wready  = 1'b0;
      next_wdata_q = s_axi_wdata_i;
      next_wstrb_q = s_axi_wstrb_i;
    end
    // Writes to decode words are accepted and ignored
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = (wa_rate || wa_dis || wa_dec) ? RESP_OK : RESP_ERR;
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (s_axi_arvalid_i && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = rd_val;
      next_rresp   = rd_ok ? RESP_OK : RESP_ERR;
    end
    if (rvalid && s_axi_rready_i) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin : bus_reg
    if (!nrst_i) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= RESP_OK;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= '0;
      rresp    <= RESP_OK;
    end else if (ce_i) begin
      awready  <= next_awready;
      wready   <= next_wready;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      awaddr_q <= next_awaddr_q;
      wdata_q  <= next_wdata_q;
      wstrb_q  <= next_wstrb_q;
      arready  <= next_arready;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  assign s_axi_awready_o = awready;
  assign s_axi_wready_o  = wready;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_arready_o = arready;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  // ------------------------------------------------------------------
  // Pacing and pulse generation
  // ------------------------------------------------------------------
  logic [NPACE-1:0][31:0] next_cnt;
  logic [NPACE-1:0]  armed, next_armed, next_dis;
  logic [31:0]       dis_merged;
  logic [NDST-1:0]   pend_q, next_pend_q, pulse, next_pulse;

  always_comb begin : pace_next
    dis_merged = merge({16'h0000, dis}, wdata_q, wstrb_q);
    next_dis   = dis;
    if (wr_go && wa_dis) begin
      next_dis = dis_merged[NPACE-1:0];
    end
    for (int d = 0; d < NDST; d++) begin
      next_pend_q[d] = pend[d];
      // Unpaced: one pulse per new pending condition
      next_pulse[d]  = pend[d] && !pend_q[d];
    end
    for (int d = 0; d < NPACE; d++) begin
      next_cnt[d]   = (cnt[d] != 32'h0) ? cnt[d] - 32'h1 : 32'h0;
      next_armed[d] = armed[d];
      if (!dis[d]) begin
        // Gap cycle keeps a re-armed fire apart from a bypass pulse
        next_pulse[d] = armed[d] && cnt[d] == 32'h0 && pend[d] && !pulse[d];
        if (next_pulse[d]) begin
          next_armed[d] = 1'b0;
        end
      end
      if (dis[d] && !next_dis[d]) begin
        next_armed[d] = 1'b1;
      end
      if (wr_go && wa_rate && awaddr_q[5:2] == 4'(d)) begin
        next_cnt[d]   = merge(cnt[d], wdata_q, wstrb_q);
        next_armed[d] = 1'b1;
        next_pulse[d] = next_pulse[d] && dis[d];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin : pace_reg
    if (!nrst_i) begin
      cnt    <= {NPACE{RATE_RST}};
      armed  <= '0;
      dis    <= DIS_RST;
      pend_q <= '0;
      pulse  <= '0;
    end else if (ce_i) begin
      cnt    <= next_cnt;
      armed  <= next_armed;
      dis    <= next_dis;
      pend_q <= next_pend_q;
      pulse  <= next_pulse;
    end
  end

  assign intr_pulse_o = pulse;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_fixed_zero;
    ce_i |=> dec[3][31:21] == 11'h0 && !dec[3][19];
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("reserved decode bit set");

  property p_db;
    ce_i && src_i.db[1][5] && route_i.db[1][5] == 4'h0 && !route_i.db_ded |=> dec[0][5];
  endproperty
  a_db: assert property (p_db) else $error("doorbell bit not decoded");

  property p_unit;
    ce_i && src_i.unit[3] && route_i.unit[3] == 4'h2 |=> dec[2][BIT_UNIT];
  endproperty
  a_unit: assert property (p_unit) else $error("unit completion not decoded");

  property p_sid;
    ce_i && src_i.sid[20] && route_i.sid[20] == 4'h1 |=> dec[1][BIT_SID_ERR];
  endproperty
  a_sid: assert property (p_sid) else $error("source-ID error not decoded");

  property p_err;
    ce_i && src_i.err[8] && route_i.err[8] == 4'h1 |=> dec[1][BIT_ERR];
  endproperty
  a_err: assert property (p_err) else $error("error event not decoded");

  property p_load;
    ce_i && wr_go && wa_rate && awaddr_q[5:2] == 4'h0 && wstrb_q == 4'hf
      |=> cnt[0] == $past(wdata_q) && armed[0];
  endproperty
  a_load: assert property (p_load) else $error("rate counter not reloaded");

  property p_count;
    ce_i && cnt[0] != 32'h0 && !(wr_go && wa_rate) |=> cnt[0] == $past(cnt[0]) - 32'h1;
  endproperty
  a_count: assert property (p_count) else $error("counter not decrementing");

  property p_once;
    ce_i && pulse[0] && !dis[0] && !(wr_go && wa_rate) ##1 ce_i && !(wr_go && wa_rate)
      |=> !pulse[0];
  endproperty
  a_once: assert property (p_once) else $error("second paced pulse");

  property p_narrow;
    ce_i |=> (pulse & $past(pulse)) == '0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("pulse wider than a clock");

  c_paced: cover property (ce_i && wr_go && wa_rate ##[1:40] pulse[0]);
  c_bypass: cover property (dis[1] && pulse[1]);
  c_dedicated: cover property (pulse[20]);
endmodule // idp_core
`default_nettype wire

// [include/idp_pkg.sv]
// Constants, types and routing helper for interrupt decode and pacing
`default_nettype none
// ----------------------------------------------------------------------
// Functional notes
// - Decode bit 20 flags routed error events
// - Decode bit 18 flags routed unit completions
// - Bit 17 source-ID error, bit 16 good
// - Bit x ORs routed doorbell bit x
// - Unit and error groups each fold into one bit
// - Unit completions reach only their chosen destination
// - Rate write reloads 32-bit counter, counts at once
// - At zero, one pulse once anything pending
// - Counter holds zero; no repulse until rewritten or pacing re-enabled
// - Writing zero permits a pulse immediately
// - Only destinations 0 to 15 are paced
// - Pacing-disable word at 0x310 bypasses pacing
// - Unrouted sources keep their pending state
// - Re-enabling re-evaluates and repulses if pending
// - Counter decrements once per clock with ce_i high
// - One decode word per destination 0 to 23
// - Source counts only where its code selects
// - Decode bit is fixed OR of mapped sources
// ----------------------------------------------------------------------
package idp_pkg;
  localparam int NDST  = 24;
  localparam int NPACE = 16;
  localparam int NDBG  = 4;
  localparam int ADDR_W = 12;
  localparam int BIT_SID_GOOD  = 16;
  localparam int BIT_SID_ERR   = 17;
  localparam int BIT_UNIT      = 18;
  localparam int BIT_ERR       = 20;
  localparam logic [ADDR_W-1:0] ADDR_DEC  = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RATE = 12'h100;
  localparam logic [ADDR_W-1:0] ADDR_DIS  = 12'h310;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam logic [15:0] DIS_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  typedef struct packed {
    logic [3:0][15:0] db;
    logic [31:0]      sid;
    logic [7:0]       unit;
    logic [16:0]      err;
  } idp_src_t;

  typedef struct packed {
    logic [3:0][15:0][3:0] db;
    logic [31:0][3:0]      sid;
    logic [7:0][3:0]       unit;
    logic [16:0][3:0]      err;
    logic                  db_ded;
  } idp_route_t;

  // Dedicated doorbell codes reach 16..23; code bit 3 set there is unused
  function automatic logic idp_hit(input logic [3:0] c, input logic ded,
                                   input logic [4:0] d);
    if (ded) begin
      return !c[3] && (d == {2'b10, c[2:0]});
    end
    return d == {1'b0, c};
  endfunction
endpackage
`default_nettype wire

// [testbench/idp_irq_sink.sv]
// Interrupt input model counting pulses per destination
`default_nettype none
module idp_irq_sink
  import idp_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic [NDST-1:0]      intr_i,
  output logic      [NDST-1:0][7:0] cnt_o,
  output logic      [7:0]           long_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NDST-1:0] prev;
  // Edge counting, so a stretched pulse shows up as a long hit
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev <= '0;
      cnt_o <= '0;
      long_o <= '0;
    end else begin
      prev <= intr_i;
      for (int d = 0; d < NDST; d++) begin
        if (intr_i[d] && !prev[d]) cnt_o[d] <= cnt_o[d] + 8'h01;
        if (intr_i[d] && prev[d]) long_o <= long_o + 8'h01;
      end
    end
  end
endmodule // idp_irq_sink
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the decode and pacing block
`default_nettype none
module tb_top;
  import idp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, awv, wv, bre, arv, rre, awr, wr_, bv, arr, rv, ce;
  logic [3:0] ws;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rdat, v;
  logic [1:0] br, rr, r;
  logic [NDST-1:0] intr;
  logic [NDST-1:0][7:0] cnt;
  logic [7:0] lng, p;
  idp_src_t src, ps;
  idp_route_t rt, pr;
  logic [511:0] big;
  int seed, cyc, n_mismatch, checks_done, dd;
  idp_core i_dut (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(ce), .src_i(src), .route_i(rt),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .intr_pulse_o(intr));
  idp_irq_sink i_sink (.sys_clk_i(clk), .nrst_i(nrst), .intr_i(intr), .cnt_o(cnt),
    .long_o(lng));
  // ----------------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (!(bv && bre));
    r = br;
    bre <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rre));
    v = rdat;
    r = rr;
    rre <= 1'b0;
  endtask
  task automatic toggle_err();
    ps.err[0] = 1'b0;
    src <= ps;
    wt(3);
    ps.err[0] = 1'b1;
    src <= ps;
    wt(5);
  endtask
  function automatic logic [31:0] exp_dec(input int d);
    logic [31:0] w;
    w = '0;
    for (int g = 0; g < NDBG; g++)
      for (int b = 0; b < 16; b++)
        if (src.db[g][b] && (rt.db_ded ? (!rt.db[g][b][3] && d == 16 + rt.db[g][b][2:0])
                                       : d == rt.db[g][b])) w[b] = 1'b1;
    for (int i = 0; i < 32; i++)
      if (src.sid[i] && d == rt.sid[i]) w[i < 16 ? 16 : 17] = 1'b1;
    for (int i = 0; i < 8; i++)
      if (src.unit[i] && d == rt.unit[i]) w[18] = 1'b1;
    for (int i = 0; i < 17; i++)
      if (src.err[i] && d == rt.err[i]) w[20] = 1'b1;
    return w;
  endfunction
  // ----------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    seed = 76269;
    n_mismatch = 0;
    checks_done = 0;
    {nrst, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
    ws = 4'hf;
    ce = 1'b1;
    src = '0;
    rt = '0;
    wt(3);
    nrst <= 1'b1;
    axr(ADDR_DIS);
    chk(v, 32'h0);
    axr(ADDR_RATE + 12'h014);
    chk(v, 32'h0);
    for (int k = 0; k < 10; k++) begin
      for (int j = 0; j < 16; j++) big[j*32 +: 32] = $random(seed);
      rt <= big[$bits(idp_route_t)-1:0];
      src <= (k == 0) ? '0 : (k == 9) ? '1 : big[511:391];
      wt(3);
      dd = {$random(seed)} % NDST;
      axr(ADDR_DEC + 12'(dd * 4));
      chk(v, exp_dec(dd));
    end
    axw(ADDR_DEC + 12'h004, 32'hffff_ffff);
    chk(32'(r), 32'(RESP_OK));
    axr(ADDR_DEC + 12'h004);
    chk(v, exp_dec(1));
    axr(12'h060);
    chk(32'(r), 32'(RESP_ERR));
    pr = '1;
    pr.db_ded = 1'b0;
    pr.db[1][5] = 4'h0;
    pr.unit[3] = 4'h2;
    pr.sid[20] = 4'h1;
    pr.err[8] = 4'h1;
    rt <= pr;
    wt(3);
    for (int i = 0; i < 3; i++) begin
      axr(ADDR_DEC + 12'(i * 4));
      chk(v, exp_dec(i));
    end
    pr = '1;
    pr.err[0] = 4'h0;
    pr.db[0][0] = 4'h0;
    ps = '0;
    src <= ps;
    rt <= pr;
    wt(4);
    p = cnt[0];
    dd = cnt[16];
    ps.err[0] = 1'b1;
    ps.db[0][0] = 1'b1;
    ps.db[2][7] = 1'b1;
    src <= ps;
    wt(5);
    chk(32'(cnt[0]), 32'(p));
    chk(32'(cnt[16]), 32'(dd + 1));
    axr(ADDR_DEC + 12'h05c);
    chk(v, exp_dec(23));
    axw(ADDR_RATE + 12'h040, 32'h5);
    chk(32'(r), 32'(RESP_ERR));
    axw(ADDR_RATE, 32'h0);
    wt(5);
    chk(32'(cnt[0]), 32'(p + 1));
    toggle_err();
    chk(32'(cnt[0]), 32'(p + 1));
    axw(ADDR_RATE, 32'd40);
    wt(38);
    chk(32'(cnt[0]), 32'(p + 1));
    wt(4);
    chk(32'(cnt[0]), 32'(p + 2));
    axr(ADDR_RATE);
    chk(v, 32'h0);
    axw(ADDR_DIS, 32'hffff_ffff);
    axr(ADDR_DIS);
    chk(v, 32'h0000_ffff);
    toggle_err();
    chk(32'(cnt[0]), 32'(p + 3));
    axw(ADDR_DIS, 32'h0);
    wt(5);
    chk(32'(cnt[0]), 32'(p + 4));
    axw(ADDR_DIS, 32'h1234_5678, 4'h2);
    axr(ADDR_DIS);
    chk(v, 32'h0000_5600);
    axw(ADDR_RATE, 32'd10);
    ce <= 1'b0;
    wt(20);
    chk(32'(cnt[0]), 32'(p + 4));
    ce <= 1'b1;
    wt(15);
    chk(32'(cnt[0]), 32'(p + 5));
    chk(32'(lng), 32'h0);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
